// [adcr_defines.vh]
`ifndef ADCR_DEFINES_VH
`define ADCR_DEFINES_VH
// register addresses (word index on the plain port)
`define ADCR_ADDR_CTRL0   3'h0
`define ADCR_ADDR_CTRL1   3'h1
`define ADCR_ADDR_TRIG    3'h2
`define ADCR_ADDR_RESH    3'h3
`define ADCR_ADDR_RESL    3'h4
`define ADCR_ADDR_STATUS  3'h5
`define ADCR_ADDR_MASK    3'h6
// field positions
`define ADCR_CH_MSB       7
`define ADCR_CH_LSB       2
`define ADCR_GO_BIT       1
`define ADCR_EN_BIT       0
`define ADCR_FMT_BIT      7
`define ADCR_CLK_MSB      6
`define ADCR_CLK_LSB      4
`define ADCR_REF_MSB      1
`define ADCR_REF_LSB      0
`define ADCR_CTRL1_MASK   8'hF3
`define ADCR_TRIG_MASK    8'h0F
`define ADCR_TRIG_OFF     4'h0
`define ADCR_TRIG_MAX     4'h0
`define ADCR_REF_RSVD     2'h1
`define ADCR_CTRL_RST     8'h00
// clock select codes
`define ADCR_CS_DIV2      3'h0
`define ADCR_CS_DIV8      3'h1
`define ADCR_CS_DIV32     3'h2
`define ADCR_CS_RC_A      3'h3
`define ADCR_CS_DIV4      3'h4
`define ADCR_CS_DIV16     3'h5
`define ADCR_CS_DIV64     3'h6
`define ADCR_CS_RC_B      3'h7
// internal channel codes
`define ADCR_CH_GND       6'h3B
`define ADCR_CH_TEMP      6'h3C
`define ADCR_CH_DAC       6'h3D
`define ADCR_CH_REF1      6'h3E
`define ADCR_CH_REF2      6'h3F
`endif

// [adcr_control.v]
`timescale 1ns/100ps
`default_nettype none
`include "adcr_defines.vh"
// register file and sequencing for a 10-bit converter core
module adcr_control #(
  parameter NTRIG = 19
) (
  input  wire             I_CLK,
  input  wire             I_RESET_N,
  input  wire [2:0]       I_ADDR,
  input  wire [7:0]       I_WDATA,
  input  wire             I_WR,
  input  wire             I_RD,
  output reg  [7:0]       O_RDATA,
  input  wire [NTRIG-1:0] I_TRIG_SRC,
  input  wire             I_CORE_DONE,
  input  wire [9:0]       I_CORE_RESULT,
  output wire             O_CORE_START,
  output wire             O_CORE_ENABLE,
  output wire [2:0]       O_CLK_SEL,
  output wire [1:0]       O_REF_SEL,
  output reg  [5:0]       O_CHANNEL,
  output reg              O_CHANNEL_VALID,
  output reg              O_CONNECT_INTERNAL,
  output wire             O_IRQ
);

  reg  [7:0]       ctrl0_r;
  reg  [7:0]       ctrl1_r;
  reg  [3:0]       trig_r;
  reg  [7:0]       resh_r;
  reg  [7:0]       resl_r;
  reg              stat_r;
  reg              mask_r;
  reg  [NTRIG-1:0] trig_d_r;
  reg              start_r;
  wire             trig_sel;
  wire             trig_edge;
  wire             wr_go;
  wire             finish;
  wire             busy;
  wire [NTRIG-1:0] rise;

  assign busy = ctrl0_r[`ADCR_GO_BIT];

  // per-source rising edge; source n sits at trigger code n+1
  genvar g;
  generate
    for (g = 0; g < NTRIG; g = g + 1) begin : g_edge
      assign rise[g] = I_TRIG_SRC[g] & ~trig_d_r[g];
    end
  endgenerate

  // code zero disables, codes past the source count select nothing
  assign trig_sel  = (trig_r != `ADCR_TRIG_OFF) && ({28'h0, trig_r} <= NTRIG);
  assign trig_edge = trig_sel && rise[trig_r - 4'h1];
  assign wr_go     = I_WR && (I_ADDR == `ADCR_ADDR_CTRL0) && I_WDATA[`ADCR_GO_BIT];
  assign finish    = busy && I_CORE_DONE;

  // a start pulse goes to the core on every start, whether the enable bit is set or not
  assign O_CORE_START  = start_r;
  assign O_CORE_ENABLE = ctrl0_r[`ADCR_EN_BIT];
  assign O_CLK_SEL     = ctrl1_r[`ADCR_CLK_MSB:`ADCR_CLK_LSB];
  assign O_REF_SEL     = ctrl1_r[`ADCR_REF_MSB:`ADCR_REF_LSB];
  assign O_IRQ         = stat_r & mask_r;

  // trigger history
  always @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      trig_d_r <= {NTRIG{1'b0}};
    end else begin
      trig_d_r <= I_TRIG_SRC;
    end
  end

  // control registers; go bit set by software or trigger, cleared on done
  always @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      ctrl0_r <= `ADCR_CTRL_RST;
      ctrl1_r <= `ADCR_CTRL_RST;
      trig_r  <= 4'h0;
      start_r <= 1'b0;
    end else begin
      start_r <= 1'b0;
      if (I_WR && I_ADDR == `ADCR_ADDR_CTRL0) begin
        ctrl0_r[`ADCR_CH_MSB:`ADCR_CH_LSB] <= I_WDATA[`ADCR_CH_MSB:`ADCR_CH_LSB];
        ctrl0_r[`ADCR_EN_BIT] <= I_WDATA[`ADCR_EN_BIT];
      end
      if (I_WR && I_ADDR == `ADCR_ADDR_CTRL1) begin
        ctrl1_r <= I_WDATA & `ADCR_CTRL1_MASK;
      end
      if (I_WR && I_ADDR == `ADCR_ADDR_TRIG) begin
        trig_r <= I_WDATA[3:0];
      end
      // a start request is ignored while busy, so completion wins in the same cycle
      if ((wr_go || trig_edge) && !busy) begin
        ctrl0_r[`ADCR_GO_BIT] <= 1'b1;
        start_r <= 1'b1;
      end else if (finish) begin
        ctrl0_r[`ADCR_GO_BIT] <= 1'b0;
      end
    end
  end

  // result registers keep content over reset; loaded at completion
  always @(posedge I_CLK) begin
    if (finish) begin
      if (ctrl1_r[`ADCR_FMT_BIT]) begin
        resh_r <= {6'h00, I_CORE_RESULT[9:8]};
        resl_r <= I_CORE_RESULT[7:0];
      end else begin
        resh_r <= I_CORE_RESULT[9:2];
        resl_r <= {I_CORE_RESULT[1:0], 6'h00};
      end
    end else begin
      if (I_WR && I_ADDR == `ADCR_ADDR_RESH) resh_r <= I_WDATA;
      if (I_WR && I_ADDR == `ADCR_ADDR_RESL) resl_r <= I_WDATA;
    end
  end

  // interrupt status: set wins over write-one-to-clear
  always @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      stat_r <= 1'b0;
      mask_r <= 1'b0;
    end else begin
      if (finish) begin
        stat_r <= 1'b1;
      end else if (I_WR && I_ADDR == `ADCR_ADDR_STATUS && I_WDATA[0]) begin
        stat_r <= 1'b0;
      end
      if (I_WR && I_ADDR == `ADCR_ADDR_MASK) mask_r <= I_WDATA[0];
    end
  end

  // channel decode to the analog mux; reserved codes connect nothing
  always @* begin
    O_CHANNEL          = ctrl0_r[`ADCR_CH_MSB:`ADCR_CH_LSB];
    O_CHANNEL_VALID    = 1'b0;
    O_CONNECT_INTERNAL = 1'b0;
    case (O_CHANNEL[5:3])
      3'h0:    O_CHANNEL_VALID = (O_CHANNEL[2:0] <= 3'h5);
      3'h1:    O_CHANNEL_VALID = O_CHANNEL[2];
      3'h2:    O_CHANNEL_VALID = 1'b1;
      3'h3:    O_CHANNEL_VALID = 1'b1;
      3'h4:    O_CHANNEL_VALID = (O_CHANNEL[2:0] <= 3'h2);
      3'h5:    O_CHANNEL_VALID = 1'b1;
      3'h7: begin
        O_CHANNEL_VALID    = (O_CHANNEL >= `ADCR_CH_GND);
        O_CONNECT_INTERNAL = O_CHANNEL_VALID;
      end
      default: O_CHANNEL_VALID = 1'b0;
    endcase
  end

  // read data one cycle after the strobe, zero otherwise
  always @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      O_RDATA <= 8'h00;
    end else if (I_RD) begin
      case (I_ADDR)
        `ADCR_ADDR_CTRL0:  O_RDATA <= ctrl0_r;
        `ADCR_ADDR_CTRL1:  O_RDATA <= ctrl1_r;
        `ADCR_ADDR_TRIG:   O_RDATA <= {4'h0, trig_r};
        `ADCR_ADDR_RESH:   O_RDATA <= resh_r;
        `ADCR_ADDR_RESL:   O_RDATA <= resl_r;
        `ADCR_ADDR_STATUS: O_RDATA <= {7'h00, stat_r};
        `ADCR_ADDR_MASK:   O_RDATA <= {7'h00, mask_r};
        default:           O_RDATA <= 8'h00;
      endcase
    end else begin
      O_RDATA <= 8'h00;
    end
  end

endmodule
`default_nettype wire

// [adcr_core_model.sv]
`timescale 1ns/100ps
`default_nettype none
// core stand-in: done after i_lat cycles
module adcr_core (
  input  wire       i_clk,
  input  wire       i_start,
  input  wire [3:0] i_lat,
  input  wire [9:0] i_val,
  output reg        o_done = 1'b0,
  output reg  [9:0] o_res = 10'h000
);
  reg [3:0] cnt_r = 4'h0;
  // result is inverted off the done cycle so a stray sample shows
  always @(posedge i_clk) begin
    o_done <= cnt_r == 4'h1;
    o_res  <= cnt_r == 4'h1 ? i_val : ~i_val;
    if (i_start) begin
      cnt_r <= i_lat;
    end else if (cnt_r != 4'h0) begin
      cnt_r <= cnt_r - 4'h1;
    end
  end
endmodule
`default_nettype wire

// [adcr_control_props.sv]
`timescale 1ns/100ps
`default_nettype none
// port checks on the register block
module adcr_control_props (
  input wire       I_CLK,
  input wire       I_RESET_N,
  input wire [2:0] I_ADDR,
  input wire [7:0] I_WDATA,
  input wire       I_WR,
  input wire       I_RD,
  input wire [7:0] O_RDATA,
  input wire       I_CORE_DONE,
  input wire       O_CORE_START,
  input wire       O_CORE_ENABLE,
  input wire [5:0] O_CHANNEL,
  input wire       O_CONNECT_INTERNAL,
  input wire       O_IRQ
);
  reg [7:0] wd_r;
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RESET_N);
  // last write data, for field mapping
  always @(posedge I_CLK) wd_r <= I_WDATA;
  chk_start_pulse: assert property (O_CORE_START |=> !O_CORE_START)
    else $error("start pulse too long");
  chk_rd_unmapped: assert property (I_RD && I_ADDR == 3'h7 |=> O_RDATA == 8'h00)
    else $error("unmapped read not zero");
  chk_ctrl1_gap: assert property (I_RD && I_ADDR == 3'h1 |=> O_RDATA[3:2] == 2'h0)
    else $error("ctrl1 gap not zero");
  chk_trig_upper: assert property (I_RD && I_ADDR == 3'h2 |=> O_RDATA[7:4] == 4'h0)
    else $error("trigger upper not zero");
  chk_internal_route: assert property (O_CONNECT_INTERNAL == (O_CHANNEL >= 6'h3B))
    else $error("internal route wrong");
  chk_enable_bit: assert property (I_WR && I_ADDR == 3'h0 |=> O_CORE_ENABLE == wd_r[0])
    else $error("enable mismatch");
  chk_channel_field: assert property (I_WR && I_ADDR == 3'h0 |=> O_CHANNEL == wd_r[7:2])
    else $error("channel mismatch");
  chk_irq_cause: assert property ($rose(O_IRQ) |-> $past(I_CORE_DONE) || $past(I_WR))
    else $error("irq without cause");
  cover property (O_CORE_START);
  cover property (O_IRQ);
  cover property (O_CONNECT_INTERNAL);
endmodule
bind adcr_control adcr_control_props chk_u (
  .I_CLK(I_CLK), .I_RESET_N(I_RESET_N), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
  .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .I_CORE_DONE(I_CORE_DONE),
  .O_CORE_START(O_CORE_START), .O_CORE_ENABLE(O_CORE_ENABLE),
  .O_CHANNEL(O_CHANNEL), .O_CONNECT_INTERNAL(O_CONNECT_INTERNAL), .O_IRQ(O_IRQ)
);
`default_nettype wire

// [adcr_control_bench.sv]
`timescale 1ns/100ps
`default_nettype none
// register level tests of the converter control block
module adcr_control_bench;
  reg        clk = 1'b0;
  reg        rst_n = 1'b0;
  reg  [2:0] addr = 3'h0;
  reg  [7:0] wdata = 8'h00;
  reg        wr = 1'b0;
  reg        rd = 1'b0;
  reg [18:0] trig = 19'h0;
  reg  [9:0] val = 10'h000;
  reg  [3:0] lat = 4'h1;
  // reference code 01 is reserved for software, so the sweep skips it
  reg  [1:0] rf = 2'h0;
  wire [7:0] rdata;
  wire [9:0] res;
  wire [5:0] chan;
  wire [2:0] csel;
  wire [1:0] rsel;
  wire       done, start, en, cval, cint, irq;
  integer    fails = 0, n_checks = 0, cyc = 0, i;
  adcr_control dut_u (
    .I_CLK(clk), .I_RESET_N(rst_n), .I_ADDR(addr), .I_WDATA(wdata),
    .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_TRIG_SRC(trig),
    .I_CORE_DONE(done), .I_CORE_RESULT(res), .O_CORE_START(start),
    .O_CORE_ENABLE(en), .O_CLK_SEL(csel), .O_REF_SEL(rsel), .O_CHANNEL(chan),
    .O_CHANNEL_VALID(cval), .O_CONNECT_INTERNAL(cint), .O_IRQ(irq)
  );
  adcr_core core_u (.i_clk(clk), .i_start(start), .i_lat(lat), .i_val(val),
    .o_done(done), .o_res(res));
  always #5 clk = ~clk;
  // hang guard, far above the roughly 120 cycles the tests need
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails = fails + 1;
      conclude;
    end
  end
  task conclude;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input string nm, input [7:0] e, input [7:0] g);
    n_checks = n_checks + 1;
    if (g !== e) begin
      fails = fails + 1;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  // one idle cycle between strobes keeps each signal to one assignment
  task wr_reg(input [2:0] a, input [7:0] d);
    @(posedge clk); addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk); wr <= 1'b0;
    #1;
  endtask
  task rd_reg(input [2:0] a, input [7:0] e, input string nm);
    @(posedge clk); addr <= a; rd <= 1'b1;
    @(posedge clk); rd <= 1'b0;
    #1 chk(nm, e, rdata);
  endtask
  task conv;
    integer k;
    k = 0;
    while (done !== 1'b1 && k < 40) begin
      @(posedge clk);
      k = k + 1;
    end
    @(posedge clk);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(3'h0, 8'h00, "ctrl0");
    rd_reg(3'h1, 8'h00, "ctrl1");
    rd_reg(3'h7, 8'h00, "unmapped");
    for (i = 0; i < 8; i = i + 1) begin
      rf = {i[1] | i[0], i[0]};
      wr_reg(3'h1, {1'b0, i[2:0], 2'b11, rf});
      rd_reg(3'h1, {1'b0, i[2:0], 2'b00, rf}, "ctrl1");
      chk("clk_sel", i[2:0], csel);
      chk("ref_sel", rf, rsel);
    end
    wr_reg(3'h2, 8'hF0);
    trig[0] <= 1'b1;
    rd_reg(3'h2, 8'h00, "trigger");
    rd_reg(3'h0, 8'h00, "trig_off");
    trig[0] <= 1'b0;
    wr_reg(3'h0, {6'h3C, 2'b01});
    rd_reg(3'h0, 8'hF1, "ctrl0");
    chk("internal", 8'h01, cint);
    chk("valid", 8'h01, cval);
    chk("enable", 8'h01, en);
    wr_reg(3'h0, 8'h20);
    chk("valid", 8'h00, cval);
    chk("enable", 8'h00, en);
    $display("test registers done");
    wr_reg(3'h6, 8'h01);
    for (i = 0; i < 2; i = i + 1) begin
      val <= i ? 10'h2C5 : 10'h1A7;
      lat <= i ? 4'h9 : 4'h1;
      wr_reg(3'h1, {i[0], 7'h00});
      wr_reg(3'h0, 8'h03);
      rd_reg(3'h0, 8'h03, "go");
      conv;
      rd_reg(3'h0, 8'h01, "go");
      chk("irq", 8'h01, irq);
      rd_reg(3'h3, i ? {6'h00, val[9:8]} : val[9:2], "res_hi");
      rd_reg(3'h4, i ? val[7:0] : {val[1:0], 6'h00}, "res_lo");
      wr_reg(3'h5, 8'h01);
      chk("irq", 8'h00, irq);
    end
    $display("test conversion done");
    wr_reg(3'h2, 8'h01);
    trig[0] <= 1'b1;
    rd_reg(3'h0, 8'h03, "hw_go");
    conv;
    rd_reg(3'h0, 8'h01, "hw_level");
    trig[0] <= 1'b0;
    wr_reg(3'h3, 8'hA5);
    rd_reg(3'h3, 8'hA5, "res_wr");
    $display("test trigger done");
    conclude;
  end
endmodule
`default_nettype wire
